// ===== rtl/ccb_pkg.sv
package ccb_pkg;
  // word index of each location: byte address is four times the index
  localparam logic [7:0] IDX_CMD_PORT       = 8'h00;
  localparam logic [7:0] IDX_GAIN_CONTROL   = 8'h60;
  localparam logic [7:0] IDX_FILTER_PATH    = 8'h61;
  localparam logic [7:0] IDX_TONE_GEN       = 8'h62;
  localparam logic [7:0] IDX_TONE_RING      = 8'h63;
  localparam logic [7:0] IDX_ANALOG_OUT     = 8'h64;
  localparam logic [7:0] IDX_ANALOG_TX      = 8'h65;
  localparam logic [7:0] IDX_RECEIVE_AMP    = 8'h66;
  localparam logic [7:0] IDX_CHANNEL_FORMAT = 8'h67;
  localparam logic [7:0] IDX_COEF_MEM_CTRL  = 8'h6f;
  localparam logic [4:0] CFG_GROUP          = 5'h0c;

  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // coef_mem_control / coef_mem_status fields
  localparam int CTL_SHADOW_BIT = 5;
  localparam int CTL_START_BIT  = 4;

  // gain_control fields
  localparam int GCR_HANDSFREE_BIT = 7;
  localparam int GCR_AGC_TX_BIT    = 6;
  localparam int GCR_AGC_RX_BIT    = 5;

  // writable bits; reserved bits read as zero
  localparam logic [7:0] MASK_FULL       = 8'hff;
  localparam logic [7:0] MASK_TONE_RING  = 8'h5c;
  localparam logic [7:0] MASK_ANALOG_OUT = 8'h1f;
  localparam logic [7:0] MASK_ANALOG_TX  = 8'hf7;

  // command word
  localparam int         CMD_DIR_BIT   = 7;
  localparam int         CMD_ZERO_BIT  = 6;
  localparam logic [1:0] CLASS_STATUS  = 2'h1;
  localparam logic [1:0] CLASS_COEF    = 2'h2;
  localparam logic [1:0] CLASS_EXT     = 2'h3;
  localparam logic [3:0] SOP_ALL_REGS  = 4'hf;
  localparam logic [3:0] XOP_VOLUME    = 4'h6;
  localparam logic [3:0] XOP_NO_OP     = 4'hf;
  localparam logic [3:0] COP_SHORT_A   = 4'h3;
  localparam logic [3:0] COP_SHORT_B   = 4'h4;
  localparam logic [3:0] COP_SHORT_C   = 4'h6;
  localparam logic [3:0] LEN_NONE      = 4'h0;
  localparam logic [3:0] LEN_STATUS    = 4'h1;
  localparam logic [3:0] LEN_ALL_REGS  = 4'h8;
  localparam logic [3:0] LEN_COEF_LONG = 4'h8;
  localparam logic [3:0] LEN_COEF_SHRT = 4'h4;
  localparam logic [3:0] LEN_VOLUME    = 4'h5;

  // coefficient locations reached by the volume sequence
  localparam logic [7:0] VOL_COEF_0 = 8'hd0;
  localparam logic [7:0] VOL_COEF_1 = 8'hd1;
  localparam logic [7:0] VOL_COEF_2 = 8'hd2;
  localparam logic [7:0] VOL_COEF_3 = 8'hd3;

  localparam logic [2:0] COPY_LAST = 3'h7;

  typedef enum logic {CS_IDLE, CS_DATA} ccb_cmd_state_e;

  typedef struct packed {
    logic [7:0] channel_data_format;
    logic [7:0] receive_amp_levels;
    logic [7:0] analog_transmit_config;
    logic [7:0] analog_output_config;
    logic [7:0] tone_ring_routing;
    logic [7:0] tone_gen_control;
    logic [7:0] filter_path_config;
    logic [7:0] gain_control;
  } ccb_cfg_s;
endpackage

// ===== rtl/ccb_top.sv
// Behaviour
// RULE_01: volume sequence five bytes; extended no-op no data
// RULE_02: direct host access to registers and coefficients
// RULE_03: coefficient memory is sixteen eight-byte blocks
// RULE_04: block n holds coefficient sequence n
// RULE_05: shadow select steers dsp to temporary block
// RULE_06: backup start copies indexed block to shadow
// RULE_07: backup busy reads one while copying
// RULE_08: host avoids coefficient access while busy
// RULE_09: dsp always sees a complete block
// RULE_10: coefficient commands back up their block automatically; here only coefficient write commands start a backup, read commands do not
// RULE_11: gain control bits; agc needs handsfree on
// RULE_12: filter path enables and highpass bypass bits
// RULE_13: tone generator control bits
// RULE_14: ring routing bits, dtmf, rest reserved
// RULE_15: single-ended speaker and four output disables
// RULE_16: transmit amp, monitor select, input mux
// RULE_17: handset and speaker output levels
// RULE_18: four two-bit channel data formats
// RULE_19: command bit seven selects write or read
// RULE_20: status op n reaches register 0x60 plus n
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ccb_top (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic [31:0]      HWDATA,
  input  wire logic             HREADY,
  output logic      [31:0]      HRDATA,
  output logic                  HREADYOUT,
  output logic                  HRESP,
  input  wire logic [6:0]       DSP_ADDR,
  output logic      [7:0]       DSP_DATA,
  output ccb_pkg::ccb_cfg_s     CFG,
  output logic                  AGC_TX_ON,
  output logic                  AGC_RX_ON,
  output logic                  BACKUP_BUSY
);

  logic [7:0]               cram_mem [128];
  logic [7:0]               shadow_mem [8];
  logic [7:0]               cfg_reg [8];
  logic                     dph_reg;
  logic                     ready_reg;
  logic                     wr_reg;
  logic [7:0]               idx_reg;
  logic [31:0]              rdata_reg;
  logic                     resp_reg;
  logic                     busy_reg;
  logic [2:0]               copy_cnt_reg;
  logic [3:0]               shadow_blk_reg;
  logic                     shadow_sel_reg;
  logic [3:0]               blk_idx_reg;
  logic                     auto_reg;
  ccb_pkg::ccb_cmd_state_e  cs_reg;
  logic [7:0]               cmdw_reg;
  logic [3:0]               cnt_reg;
  logic [3:0]               len_reg;
  logic [7:0]               dsp_data_reg;
  logic                     agc_tx_reg;
  logic                     agc_rx_reg;

  function automatic logic [7:0] cfg_mask(input logic [2:0] sel);
    case (sel)
      3'h0: cfg_mask = ccb_pkg::MASK_FULL;        // RULE_11
      3'h1: cfg_mask = ccb_pkg::MASK_FULL;        // RULE_12
      3'h2: cfg_mask = ccb_pkg::MASK_FULL;        // RULE_13
      3'h3: cfg_mask = ccb_pkg::MASK_TONE_RING;   // RULE_14
      3'h4: cfg_mask = ccb_pkg::MASK_ANALOG_OUT;  // RULE_15
      3'h5: cfg_mask = ccb_pkg::MASK_ANALOG_TX;   // RULE_16
      3'h6: cfg_mask = ccb_pkg::MASK_FULL;        // RULE_17
      default: cfg_mask = ccb_pkg::MASK_FULL;     // RULE_18
    endcase
  endfunction

  // bus decode
  logic        addr_take;
  logic        is_cmd;
  logic        cmd_data;
  logic [1:0]  cmd_class;
  logic [3:0]  cmd_n;
  logic [7:0]  sop_tgt;
  logic [7:0]  cop_tgt;
  logic [7:0]  vol_tgt;
  logic [7:0]  xop_tgt;
  logic [7:0]  cmd_tgt;
  logic [7:0]  eff_idx;
  logic        in_cram;
  logic        in_cfg;
  logic        is_ctrl;
  logic        stall;
  logic        act;
  logic        do_wr;
  logic [7:0]  wdata;
  logic [2:0]  cfg_sel;
  logic [7:0]  status_byte;
  logic [7:0]  rd_val;
  logic [7:0]  rd_byte;

  assign addr_take = HSEL & HTRANS[1] & HREADY;
  assign is_cmd    = idx_reg == ccb_pkg::IDX_CMD_PORT;
  assign cmd_data  = is_cmd & (cs_reg == ccb_pkg::CS_DATA);
  assign cmd_class = cmdw_reg[5:4];
  assign cmd_n     = cmdw_reg[3:0];

  // status op n lands on 0x60+n; the all-register op walks down from 0x67
  assign sop_tgt = (cmd_n == ccb_pkg::SOP_ALL_REGS) ?
                   ccb_pkg::IDX_CHANNEL_FORMAT - {4'h0, cnt_reg} :
                   ccb_pkg::IDX_GAIN_CONTROL + {4'h0, cmd_n};  // RULE_20
  assign cop_tgt = {1'b1, cmd_n, cnt_reg[2:0]};  // RULE_03 RULE_04
  assign vol_tgt = (cnt_reg[1:0] == 2'h1) ? ccb_pkg::VOL_COEF_0 :
                   (cnt_reg[1:0] == 2'h2) ? ccb_pkg::VOL_COEF_1 :
                   (cnt_reg[1:0] == 2'h3) ? ccb_pkg::VOL_COEF_2 :
                   ccb_pkg::VOL_COEF_3;
  assign xop_tgt = (cnt_reg == 4'h0) ? ccb_pkg::IDX_RECEIVE_AMP : vol_tgt;  // RULE_01
  assign cmd_tgt = (cmd_class == ccb_pkg::CLASS_STATUS) ? sop_tgt :
                   (cmd_class == ccb_pkg::CLASS_COEF) ? cop_tgt : xop_tgt;

  // direct accesses use the bus index, command bytes their translated target
  assign eff_idx = is_cmd ? cmd_tgt : idx_reg;  // RULE_02
  assign in_cram = eff_idx[7];
  assign in_cfg  = eff_idx[7:3] == ccb_pkg::CFG_GROUP;
  assign is_ctrl = eff_idx == ccb_pkg::IDX_COEF_MEM_CTRL;
  assign cfg_sel = eff_idx[2:0];

  // wait states instead of corrupting a copy in flight
  assign stall = busy_reg & (in_cram | is_cmd);  // RULE_08 RULE_09
  assign act   = dph_reg & ~ready_reg & ~stall;
  assign do_wr = act & (is_cmd ? cmd_data & ~cmdw_reg[ccb_pkg::CMD_DIR_BIT] : wr_reg);  // RULE_19
  assign wdata = HWDATA[7:0];

  assign status_byte = {2'h0, shadow_sel_reg, busy_reg, blk_idx_reg};  // RULE_07
  assign rd_val  = in_cram ? cram_mem[eff_idx[6:0]] :
                   in_cfg ? cfg_reg[cfg_sel] :
                   is_ctrl ? status_byte : 8'h00;
  assign rd_byte = (is_cmd & ~cmd_data) ? 8'h00 : rd_val;

  // command word intake
  logic        word_take;
  logic [1:0]  w_class;
  logic [3:0]  w_n;
  logic        w_short;
  logic [3:0]  sop_len;
  logic [3:0]  cop_len;
  logic [3:0]  xop_len;
  logic [3:0]  w_len;
  logic        byte_step;
  logic        seq_last;

  assign word_take = act & is_cmd & wr_reg & (cs_reg == ccb_pkg::CS_IDLE);
  assign w_class   = wdata[5:4];
  assign w_n       = wdata[3:0];
  assign w_short   = (w_n == ccb_pkg::COP_SHORT_A) | (w_n == ccb_pkg::COP_SHORT_B) |
                     (w_n == ccb_pkg::COP_SHORT_C);
  assign sop_len   = (w_n == ccb_pkg::SOP_ALL_REGS) ? ccb_pkg::LEN_ALL_REGS :
                     ccb_pkg::LEN_STATUS;
  assign cop_len   = w_short ? ccb_pkg::LEN_COEF_SHRT : ccb_pkg::LEN_COEF_LONG;
  // the no-op and undefined extended codes carry no data
  assign xop_len   = (w_n == ccb_pkg::XOP_VOLUME) ? ccb_pkg::LEN_VOLUME :
                     ccb_pkg::LEN_NONE;  // RULE_01
  assign w_len     = wdata[ccb_pkg::CMD_ZERO_BIT] ? ccb_pkg::LEN_NONE :
                     (w_class == ccb_pkg::CLASS_STATUS) ? sop_len :
                     (w_class == ccb_pkg::CLASS_COEF) ? cop_len :
                     (w_class == ccb_pkg::CLASS_EXT) ? xop_len : ccb_pkg::LEN_NONE;
  assign byte_step = act & cmd_data;
  assign seq_last  = cnt_reg == (len_reg - 4'h1);

  // backup start from control register or from a coefficient write command
  logic        ctrl_wr;
  logic        cop_auto;
  logic        start;
  logic [3:0]  start_blk;

  assign ctrl_wr   = do_wr & is_ctrl;
  assign cop_auto  = word_take & ~wdata[ccb_pkg::CMD_ZERO_BIT] &
                     (w_class == ccb_pkg::CLASS_COEF) & ~wdata[ccb_pkg::CMD_DIR_BIT];  // RULE_10
  assign start     = ((ctrl_wr & wdata[ccb_pkg::CTL_START_BIT]) | cop_auto) & ~busy_reg;  // RULE_06
  assign start_blk = cop_auto ? w_n : wdata[3:0];

  // dsp reads the shadow only once it holds the whole block
  logic        use_sh;
  logic [7:0]  sh_byte;
  logic [7:0]  gcr;

  assign use_sh  = (shadow_sel_reg | auto_reg) & ~busy_reg &
                   (DSP_ADDR[6:3] == shadow_blk_reg);  // RULE_05 RULE_09
  assign sh_byte = shadow_mem[DSP_ADDR[2:0]];
  assign gcr     = cfg_reg[0];

  always_ff @(posedge CLK) begin
    if (RST) begin
      dph_reg   <= 1'b0;
      ready_reg <= 1'b1;
      wr_reg    <= 1'b0;
      idx_reg   <= 8'h00;
    end else if (addr_take) begin
      dph_reg   <= 1'b1;
      ready_reg <= 1'b0;
      wr_reg    <= HWRITE;
      idx_reg   <= HADDR[9:2];
    end else if (act) begin
      ready_reg <= 1'b1;
    end else if (ready_reg) begin
      dph_reg   <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (act) begin
      rdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // never an error answer
  always_ff @(posedge CLK) begin
    resp_reg <= 1'b0;
  end

  generate
    for (genvar i = 0; i < 8; i++) begin : g_cfg
      always_ff @(posedge CLK) begin
        if (RST) begin
          cfg_reg[i] <= ccb_pkg::CFG_RESET;
        end else if (do_wr & in_cfg & (cfg_sel == 3'(i))) begin
          cfg_reg[i] <= wdata & cfg_mask(3'(i));  // RULE_11 RULE_12 RULE_13 RULE_14
        end
      end
    end
  endgenerate

  // no reset on the coefficient store: contents are loaded by software
  always_ff @(posedge CLK) begin
    if (do_wr & in_cram) begin
      cram_mem[eff_idx[6:0]] <= wdata;  // RULE_02
    end
  end

  always_ff @(posedge CLK) begin
    if (busy_reg) begin
      shadow_mem[copy_cnt_reg] <= cram_mem[{shadow_blk_reg, copy_cnt_reg}];  // RULE_06
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      busy_reg       <= 1'b0;
      copy_cnt_reg   <= 3'h0;
      shadow_blk_reg <= 4'h0;
    end else if (start) begin
      busy_reg       <= 1'b1;
      copy_cnt_reg   <= 3'h0;
      shadow_blk_reg <= start_blk;
    end else if (busy_reg) begin
      copy_cnt_reg   <= copy_cnt_reg + 3'h1;
      busy_reg       <= copy_cnt_reg != ccb_pkg::COPY_LAST;  // RULE_07
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      shadow_sel_reg <= ccb_pkg::CTRL_RESET[ccb_pkg::CTL_SHADOW_BIT];
      blk_idx_reg    <= ccb_pkg::CTRL_RESET[3:0];
    end else if (ctrl_wr) begin
      shadow_sel_reg <= wdata[ccb_pkg::CTL_SHADOW_BIT];  // RULE_05
      blk_idx_reg    <= wdata[3:0];  // RULE_03
    end
  end

  // auto shadowing lasts until the last byte of the coefficient command
  always_ff @(posedge CLK) begin
    if (RST) begin
      auto_reg <= 1'b0;
    end else if (cop_auto) begin
      auto_reg <= 1'b1;  // RULE_10
    end else if (byte_step & seq_last) begin
      auto_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cs_reg   <= ccb_pkg::CS_IDLE;
      cmdw_reg <= 8'h00;
      cnt_reg  <= 4'h0;
      len_reg  <= 4'h0;
    end else begin
      case (cs_reg)
        ccb_pkg::CS_IDLE: begin
          if (word_take) begin
            cmdw_reg <= wdata;
            cnt_reg  <= 4'h0;
            len_reg  <= w_len;
            if (w_len != ccb_pkg::LEN_NONE) begin
              cs_reg <= ccb_pkg::CS_DATA;  // RULE_01
            end
          end
        end
        default: begin
          if (byte_step) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (seq_last) begin
              cs_reg <= ccb_pkg::CS_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      dsp_data_reg <= 8'h00;
      agc_tx_reg   <= 1'b0;
      agc_rx_reg   <= 1'b0;
    end else begin
      dsp_data_reg <= use_sh ? sh_byte : cram_mem[DSP_ADDR];  // RULE_05
      agc_tx_reg   <= gcr[ccb_pkg::GCR_HANDSFREE_BIT] & gcr[ccb_pkg::GCR_AGC_TX_BIT];  // RULE_11
      agc_rx_reg   <= gcr[ccb_pkg::GCR_HANDSFREE_BIT] & gcr[ccb_pkg::GCR_AGC_RX_BIT];  // RULE_11
    end
  end

  assign HRDATA      = rdata_reg;
  assign HREADYOUT   = ready_reg;
  assign HRESP       = resp_reg;
  assign DSP_DATA    = dsp_data_reg;
  assign AGC_TX_ON   = agc_tx_reg;
  assign AGC_RX_ON   = agc_rx_reg;
  assign BACKUP_BUSY = busy_reg;
  assign CFG = {cfg_reg[7], cfg_reg[6], cfg_reg[5], cfg_reg[4],
                cfg_reg[3], cfg_reg[2], cfg_reg[1], cfg_reg[0]};

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence copy_run;
    busy_reg [*8] ##1 !busy_reg;
  endsequence

  sequence data_phase;
    !ready_reg ##1 ready_reg;
  endsequence

  busy_len_a: assert property ($rose(busy_reg) |-> copy_run)  // RULE_07
    else $error("backup busy not eight cycles");
  copy_ok_a: assert property (
    $fell(busy_reg) |-> shadow_mem[7] == cram_mem[{shadow_blk_reg, 3'h7}])  // RULE_06
    else $error("shadow block differs from source");
  start_busy_a: assert property (start |=> busy_reg && copy_cnt_reg == 3'h0)  // RULE_06
    else $error("backup did not start");
  dsp_shadow_a: assert property (use_sh |=> DSP_DATA == $past(sh_byte))  // RULE_05
    else $error("dsp not served from shadow");
  cram_stall_a: assert property (
    dph_reg && !ready_reg && busy_reg && in_cram |=> !ready_reg)  // RULE_08
    else $error("coefficient access not held while busy");
  sop_write_a: assert property (
    do_wr && is_cmd && cmd_class == ccb_pkg::CLASS_STATUS && cmd_n == 4'h6
    |=> cfg_reg[6] == $past(wdata))  // RULE_20
    else $error("status op did not write register");
  cop_auto_a: assert property (cop_auto |=> busy_reg && auto_reg)  // RULE_10
    else $error("coefficient command without backup");
  vol_len_a: assert property (
    word_take && wdata[6:0] == 7'h36 |=> len_reg == 4'h5 && cs_reg == ccb_pkg::CS_DATA)  // RULE_01
    else $error("volume sequence length wrong");
  agc_gate_a: assert property (
    AGC_TX_ON == ($past(gcr[7]) & $past(gcr[6])))  // RULE_11
    else $error("agc not gated by handsfree");
  ring_mask_a: assert property ((cfg_reg[3] & ~ccb_pkg::MASK_TONE_RING) == 8'h00)  // RULE_14
    else $error("reserved routing bits set");
  bus_phase_a: assert property (addr_take && !busy_reg |=> data_phase)  // RULE_02
    else $error("data phase not one wait state");

endmodule

// ===== tb/ccb_host_model.sv
`timescale 1ns/1ps
// host microcontroller: one AHB-Lite master doing single word transfers
module ccb_host_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        backup_busy,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // no wait count assumed; the bench timeout cuts a hang
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
    if (idx[7]) begin
      while (backup_busy !== 1'b0) @(posedge clk);
    end
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    haddr  <= ~haddr;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    // released data lines must not keep looking valid
    hwdata <= ~hwdata;
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic                CLK;
  logic                RST;
  logic [6:0]          dsp_addr;
  wire logic           hsel;
  wire logic [31:0]    haddr;
  wire logic [1:0]     htrans;
  wire logic           hwrite;
  wire logic [2:0]     hsize;
  wire logic [31:0]    hwdata;
  wire logic [31:0]    hrdata;
  wire logic           hready;
  wire logic           hresp;
  wire logic [7:0]     dsp_data;
  wire ccb_pkg::ccb_cfg_s cfg;
  wire logic           agc_tx;
  wire logic           agc_rx;
  wire logic           busy;
  wire logic [63:0]    cfg_w;
  int                  n_errors = 0;
  int                  total_checks = 0;
  int                  cycles = 0;
  int                  cnt;
  logic [7:0]          msk [8] = '{8'hff, 8'hff, 8'hff, 8'h5c, 8'h1f, 8'hf7, 8'hff, 8'hff};

  assign cfg_w = cfg;

  ccb_host_model u_host (.clk(CLK), .hready(hready), .hrdata(hrdata), .backup_busy(busy),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  ccb_top u_dut (.CLK(CLK), .RST(RST), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .DSP_ADDR(dsp_addr), .DSP_DATA(dsp_data),
    .CFG(cfg), .AGC_TX_ON(agc_tx), .AGC_RX_ON(agc_rx), .BACKUP_BUSY(busy));

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  // a full pass takes under a thousand cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    u_host.xfer(1'b1, idx, d, r);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] r;
    u_host.xfer(1'b0, idx, 8'h00, r);
    check(r, {24'h0, e});
    check({31'h0, hresp}, 32'h0);
  endtask

  // dsp output is registered from the index seen at the previous edge
  task automatic dsp(input logic [6:0] a, input logic [7:0] e);
    @(posedge CLK);
    dsp_addr <= a;
    repeat (2) @(posedge CLK);
    #1;
    check({24'h0, dsp_data}, {24'h0, e});
  endtask

  function automatic logic [7:0] sv(input int n);
    return msk[n] & 8'(17 * (n + 1));
  endfunction

  initial begin
    RST = 1'b1;
    dsp_addr = 7'h0;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    #1;
    check(cfg_w[31:0], 32'h0);
    check(cfg_w[63:32], 32'h0);
    check({31'h0, busy}, 32'h0);
    for (int n = 0; n < 8; n++) rd(8'(8'h60 + n), 8'h00);
    rd(8'h6f, 8'h00);
    for (int n = 0; n < 8; n++) begin
      wr(8'(8'h60 + n), 8'hff);
      rd(8'(8'h60 + n), msk[n]);
      check({24'h0, cfg_w[8*n +: 8]}, {24'h0, msk[n]});
    end
    // agc bits only act with handsfree on
    wr(8'h60, 8'h60);
    @(posedge CLK);
    #1 check({30'h0, agc_tx, agc_rx}, 32'h0);
    wr(8'h60, 8'ha0);
    @(posedge CLK);
    #1 check({30'h0, agc_tx, agc_rx}, 32'h1);
    wr(8'h60, 8'hc0);
    @(posedge CLK);
    #1 check({30'h0, agc_tx, agc_rx}, 32'h2);
    wr(8'h68, 8'h5a);
    rd(8'h68, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(8'(8'h90 + k), 8'(8'h30 + k));
      wr(8'(8'hf8 + k), 8'(8'hc0 + k));
    end
    for (int k = 0; k < 8; k++) begin
      rd(8'(8'h90 + k), 8'(8'h30 + k));
      rd(8'(8'hf8 + k), 8'(8'hc0 + k));
    end
    // block 3 gets defined bytes before any backup copies it
    for (int k = 8; k < 16; k++) wr(8'(8'h90 + k), 8'(8'h30 + k));
    dsp(7'h17, 8'h37);
    dsp(7'h7f, 8'hc7);
    // backup of block 2, then edit the original under shadow
    wr(8'h6f, 8'h12);
    #1;
    // busy already ran one cycle when the data phase ended
    cnt = 1;
    while (busy === 1'b1 && cnt < 20) begin
      cnt++;
      @(posedge CLK);
      #1;
    end
    check(32'(cnt), 32'h8);
    rd(8'h6f, 8'h02);
    wr(8'h6f, 8'h22);
    wr(8'h90, 8'h99);
    dsp(7'h10, 8'h30);
    rd(8'h6f, 8'h22);
    wr(8'h6f, 8'h02);
    dsp(7'h10, 8'h99);
    // status ops through the command port
    for (int n = 0; n < 8; n++) begin
      wr(8'h00, 8'(8'h10 + n));
      wr(8'h00, 8'(8'h11 * (n + 1)));
      rd(8'(8'h60 + n), sv(n));
    end
    for (int n = 0; n < 8; n++) begin
      wr(8'h00, 8'(8'h90 + n));
      rd(8'h00, sv(n));
    end
    wr(8'h00, 8'h9f);
    for (int n = 7; n >= 0; n--) rd(8'h00, sv(n));
    // volume sequence, then no-op leaves no sequence open
    wr(8'h00, 8'h36);
    wr(8'h00, 8'h4b);
    for (int k = 0; k < 4; k++) wr(8'h00, 8'(8'he0 + k));
    rd(8'h66, 8'h4b);
    for (int k = 0; k < 4; k++) rd(8'(8'hd0 + k), 8'(8'he0 + k));
    wr(8'h00, 8'h3f);
    rd(8'h00, 8'h00);
    // coefficient op: dsp keeps the old block until the sequence ends
    for (int k = 0; k < 8; k++) wr(8'(8'h88 + k), 8'(8'h10 + k));
    wr(8'h00, 8'h21);
    wr(8'h00, 8'ha0);
    dsp(7'h08, 8'h10);
    for (int k = 1; k < 8; k++) wr(8'h00, 8'(8'ha0 + k));
    dsp(7'h08, 8'ha0);
    for (int k = 0; k < 8; k++) rd(8'(8'h88 + k), 8'(8'ha0 + k));
    // coefficient read command walks the same block through the port
    wr(8'h00, 8'ha1);
    for (int k = 0; k < 8; k++) rd(8'h00, 8'(8'ha0 + k));
    // short block: four bytes only, fifth port write is a new command
    wr(8'h9c, 8'h55);
    wr(8'h00, 8'h23);
    for (int k = 0; k < 4; k++) wr(8'h00, 8'(8'hb0 + k));
    wr(8'h00, 8'h3f);
    rd(8'h9c, 8'h55);
    for (int k = 0; k < 4; k++) rd(8'(8'h98 + k), 8'(8'hb0 + k));
    stop_test();
  end
endmodule
